// file: bench/sfce_host.sv
// Host controller model driving the clear pin
`timescale 1ns/1ns
`default_nettype none
module sfce_host (
	input wire logic mclk_i,
	input wire logic clr_req_i,
	output logic fault_clear_n_o
);
	initial fault_clear_n_o = 1'b1;
	// Pulled to 0V on request, away from the sampling edge
	always @(negedge mclk_i) fault_clear_n_o <= !clr_req_i;
endmodule : sfce_host
`default_nettype wire

// file: bench/sfce_properties.sv
// Port checker for the fault code encoder
`timescale 1ns/1ns
`default_nettype none
module sfce_properties (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [sfce_pkg::FAULT_W:0] fault_i,
	input wire logic panel_link_fail_i,
	input wire logic panel_clear_i,
	input wire logic fault_clear_n_i,
	input wire logic fault_flag_out_o,
	input wire logic code_line_1_o,
	input wire logic code_line_2_o,
	input wire logic code_line_3_o,
	input wire logic [3:0] category_o
);
	import sfce_pkg::*;
	logic [2:0] hi_q;
	logic [2:0] hi_d;
	logic [2:0] code;
	logic quiet;
	always_comb begin
		hi_d = fault_clear_n_i ? hi_q + {2'h0, hi_q != 3'h7} : 3'h0;
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hi_q <= 3'h0;
		end else begin
			hi_q <= hi_d;
		end
	end
	assign code = {code_line_3_o, code_line_2_o, code_line_1_o};
	// Pin high long enough to have left the sync chain
	assign quiet = hi_q == 3'h7 && !panel_clear_i && !panel_link_fail_i;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	chk_idle_lines: assert property (fault_flag_out_o |-> code == CODE_NONE)
		else $error("lines on while normal");
	chk_fault_alarm: assert property (quiet && fault_flag_out_o && |fault_i |=> !fault_flag_out_o)
		else $error("fault not flagged");
	chk_flag_latch: assert property (quiet && !fault_flag_out_o |=> !fault_flag_out_o)
		else $error("alarm dropped without clear");
	chk_code_hold: assert property (quiet && !fault_flag_out_o |=> $stable(code))
		else $error("code changed in alarm");
	chk_pin_clear: assert property ((!fault_clear_n_i && !panel_link_fail_i) [*6] |-> fault_flag_out_o)
		else $error("pin clear late");
	chk_panel_clear: assert property (panel_clear_i && !panel_link_fail_i |=> fault_flag_out_o)
		else $error("panel clear missed");
	chk_oc_code: assert property (quiet && fault_flag_out_o && fault_i == 11'h001 |=> code == CODE_OC)
		else $error("overcurrent code wrong");
	chk_speed_code: assert property (quiet && fault_flag_out_o && fault_i == 11'h020 |=> code == CODE_SPEED)
		else $error("overspeed code wrong");
	chk_ovld_code: assert property (quiet && fault_flag_out_o && fault_i == 11'h040 |=> code == CODE_OVLD)
		else $error("overload code wrong");
	cover property (quiet && fault_flag_out_o && |fault_i);
	cover property (!fault_clear_n_i [*6]);
	cover property (panel_clear_i && !fault_flag_out_o);
endmodule : sfce_properties
bind sfce_top sfce_properties i_sfce_properties (.mclk_i(mclk_i), .nrst_i(nrst_i),
	.fault_i(fault_i), .panel_link_fail_i(panel_link_fail_i), .panel_clear_i(panel_clear_i),
	.fault_clear_n_i(fault_clear_n_i), .fault_flag_out_o(fault_flag_out_o),
	.code_line_1_o(code_line_1_o), .code_line_2_o(code_line_2_o),
	.code_line_3_o(code_line_3_o), .category_o(category_o));
`default_nettype wire

// file: bench/test_servo_fault_code_encoder.sv
// Testbench of the fault code encoder
`timescale 1ns/1ns
`default_nettype none
module test_servo_fault_code_encoder;
	import sfce_pkg::*;
	logic mclk = 0, nrst_n = 0, link = 0, pclr = 0, creq = 0, clr_n, flag, l1, l2, l3;
	logic [FAULT_W:0] fault = '0;
	logic [3:0] cat;
	int fail_count = 0, n_tests = 0, cyc = 0;
	logic [2:0] tab [0:10] = '{CODE_OC, CODE_FUSE, CODE_REGEN, CODE_REGEN, CODE_VOLT,
		CODE_SPEED, CODE_OVLD, CODE_NONE, CODE_NONE, CODE_SPEED, CODE_NONE};
	sfce_top i_sfce_top (.mclk_i(mclk), .nrst_i(nrst_n), .fault_i(fault), .panel_link_fail_i(link),
		.panel_clear_i(pclr), .fault_clear_n_i(clr_n), .fault_flag_out_o(flag),
		.code_line_1_o(l1), .code_line_2_o(l2), .code_line_3_o(l3), .category_o(cat));
	sfce_host i_sfce_host (.mclk_i(mclk), .clr_req_i(creq), .fault_clear_n_o(clr_n));
	always #5 mclk = ~mclk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(negedge mclk);
	endtask : w
	task automatic clear_pin;
		creq = 1;
		w(8);
		creq = 0;
		w(10);
	endtask : clear_pin
	task automatic t_codes;
		for (int b = 0; b <= FAULT_W; b++) begin
			fault[b] = 1'b1;
			w(1);
			fault = '0;
			w(2);
			chk({flag, l3, l2, l1}, {1'b0, tab[b]});
			if (b == F_PARAM) chk(cat, CAT_PARAM);
			clear_pin();
			chk({flag, l3, l2, l1}, 4'h8);
		end
		$display("codes done");
	endtask : t_codes
	task automatic t_first;
		fault = 11'h010;
		w(1);
		fault = 11'h041;
		w(2);
		chk({flag, l3, l2, l1}, {1'b0, CODE_VOLT});
		fault = '0;
		clear_pin();
		$display("first done");
	endtask : t_first
	task automatic t_clears;
		fault = 11'h002;
		w(1);
		fault = '0;
		pclr = 1;
		w(1);
		pclr = 0;
		w(1);
		chk({flag, l3, l2, l1}, 4'h8);
		fault = 11'h040;
		w(2);
		nrst_n = 0;
		w(1);
		chk({flag, l3, l2, l1, cat}, 8'h8F);
		nrst_n = 1;
		fault = '0;
		link = 1;
		w(3);
		chk({flag, l3, l2, l1}, 4'h0);
		link = 0;
		clear_pin();
		chk({flag, l3, l2, l1}, 4'h8);
		$display("clears done");
	endtask : t_clears
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		w(16);
		chk({flag, l3, l2, l1, cat}, 8'h8F);
		nrst_n = 1;
		w(10);
		t_codes();
		t_first();
		t_clears();
		print_verdict();
	end
endmodule : test_servo_fault_code_encoder
`default_nettype wire

// file: common/sfce_pkg.sv
// Constants and types for the servo fault code encoder
package sfce_pkg;
	// Fault classes presented by the monitors, one bit each
	localparam int FAULT_W = 10;
	localparam int F_OVERCURRENT = 0;
	localparam int F_FUSE = 1;
	localparam int F_REGEN = 2;
	localparam int F_POS_OVERFLOW = 3;
	localparam int F_BUS_VOLTAGE = 4;
	localparam int F_OVERSPEED = 5;
	localparam int F_OVERLOAD = 6;
	localparam int F_ABS_ENCODER = 7;
	localparam int F_REF_READ = 8;
	localparam int F_OVERRUN = 9;
	localparam int F_PARAM = 10;
	// Category code shown locally for parameter faults only
	localparam logic [3:0] CAT_PARAM = 4'h0;
	localparam logic [3:0] CAT_NONE = 4'hF;
	// Code line patterns {line3,line2,line1}, 1 = transistor on
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_OC = 3'h1;
	localparam logic [2:0] CODE_FUSE = 3'h2;
	localparam logic [2:0] CODE_REGEN = 3'h3;
	localparam logic [2:0] CODE_VOLT = 3'h4;
	localparam logic [2:0] CODE_SPEED = 3'h5;
	localparam logic [2:0] CODE_OVLD = 3'h7;
	localparam int SYNC_W = 3;
	typedef enum logic [1:0] {
		SFCE_NORMAL,
		SFCE_ALARM,
		SFCE_UNDEF
	} sfce_state_e;
endpackage : sfce_pkg

// file: src/sfce_top.sv
// Fault latch and alarm code encoder of the servo drive
//
// Notes on behaviour
// R1: Overcurrent/overheat line1; fuse blown line2
// R2: Regenerative failure drives lines 1 and 2
// R3: Position error overflow drives lines 1,2
// R4: Bus over/undervoltage drives only line3
// R5: Overspeed drives lines 1 and 3
// R6: Overload drives all three lines
// R7: Absolute encoder fault: no lines, alarm flag
// R8: Reference read failure: no lines, alarm
// R9: Overrun or encoder disconnect: lines 1,3
// R10: Parameter fault: no lines, show category
// R11: Panel link failure: outputs undefined
// R12: No fault: lines off, flag transistor on
// R13: Any fault turns flag transistor off; a fault during an active clear is not latched
// R14: Low clear input resets latched alarm
// R15: Panel clear and power cycle clear too
// R16: Fault stays latched until a clear
// R17: First latched fault holds the code
`timescale 1ns/1ns
`default_nettype none
module sfce_top (
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Fault pulses or levels from the monitors, same clock domain
	input wire logic [sfce_pkg::FAULT_W:0] fault_i,
	// Loss of link to the handheld operator panel, same clock domain
	input wire logic panel_link_fail_i,
	// Clear request from the operator panel, same clock domain
	input wire logic panel_clear_i,
	// Low-active clear pin from the host
	input wire logic fault_clear_n_i,
	// High when the flag output transistor conducts (normal state)
	output logic fault_flag_out_o,
	output logic code_line_1_o,
	output logic code_line_2_o,
	output logic code_line_3_o,
	output logic [3:0] category_o
);
	import sfce_pkg::*;

	logic [SYNC_W-1:0] clr_sync_q;
	logic [SYNC_W-1:0] clr_sync_d;
	logic clr_level_q;
	logic clr_level_d;
	sfce_state_e state_q;
	sfce_state_e state_d;
	logic [2:0] code_q;
	logic [2:0] code_d;
	logic [3:0] cat_q;
	logic [3:0] cat_d;
	logic flag_q;
	logic flag_d;
	logic clear_evt;

	// Maps the lowest-numbered active fault among bits 0-6 and 9 to its line pattern
	function automatic logic [2:0] fault_code(input logic [FAULT_W:0] f);
		logic [2:0] c;
		c = CODE_NONE;
		if (f[F_OVERCURRENT]) begin
			c = CODE_OC; // R1
		end else if (f[F_FUSE]) begin
			c = CODE_FUSE; // R1
		end else if (f[F_REGEN]) begin
			c = CODE_REGEN; // R2
		end else if (f[F_POS_OVERFLOW]) begin
			c = CODE_REGEN; // R3
		end else if (f[F_BUS_VOLTAGE]) begin
			c = CODE_VOLT; // R4
		end else if (f[F_OVERSPEED]) begin
			c = CODE_SPEED; // R5
		end else if (f[F_OVERLOAD]) begin
			c = CODE_OVLD; // R6
		end else if (f[F_OVERRUN]) begin
			c = CODE_SPEED; // R9
		end else begin
			c = CODE_NONE; // R7 R8 R10
		end
		return c;
	endfunction : fault_code

	// Pin synchroniser: a level change counts once stages two and three agree
	always_comb begin
		clr_sync_d = {clr_sync_q[SYNC_W-2:0], fault_clear_n_i};
		clr_level_d = clr_level_q;
		if (clr_sync_q[1] == clr_sync_q[2]) begin
			clr_level_d = clr_sync_q[2];
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clr_sync_q <= '1;
			clr_level_q <= 1'b1;
		end else begin
			clr_sync_q <= clr_sync_d;
			clr_level_q <= clr_level_d;
		end
	end

	// Host low level or panel command clears; power cycle is the reset itself
	assign clear_evt = !clr_level_q || panel_clear_i; // R14 R15

	always_comb begin
		state_d = state_q;
		code_d = code_q;
		cat_d = cat_q;
		flag_d = flag_q;
		case (state_q)
			SFCE_NORMAL: begin
				code_d = CODE_NONE; // R12
				cat_d = CAT_NONE;
				flag_d = 1'b1; // R12
				if (panel_link_fail_i) begin
					state_d = SFCE_UNDEF; // R11
				end else if (|fault_i && !clear_evt) begin
					// Clear held low keeps the drive from latching
					state_d = SFCE_ALARM;
					code_d = fault_code(fault_i); // R17
					cat_d = fault_i[F_PARAM] ? CAT_PARAM : CAT_NONE; // R10
					flag_d = 1'b0; // R13
				end
			end
			SFCE_ALARM: begin
				// Later faults ignored; held even after cause goes away
				if (clear_evt) begin // R16
					state_d = SFCE_NORMAL; // R14
					code_d = CODE_NONE;
					cat_d = CAT_NONE;
					flag_d = 1'b1;
				end else if (panel_link_fail_i) begin
					state_d = SFCE_UNDEF;
				end
			end
			SFCE_UNDEF: begin
				// Host must not trust the pins here; we hold alarm as the safe choice
				flag_d = 1'b0; // R11
				code_d = CODE_NONE;
				if (!panel_link_fail_i && clear_evt) begin
					state_d = SFCE_NORMAL;
					flag_d = 1'b1;
					cat_d = CAT_NONE;
				end
			end
			default: begin
				state_d = SFCE_NORMAL;
				code_d = CODE_NONE;
				cat_d = CAT_NONE;
				flag_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= SFCE_NORMAL; // R15
			code_q <= CODE_NONE;
			cat_q <= CAT_NONE;
			flag_q <= 1'b1;
		end else begin
			state_q <= state_d;
			code_q <= code_d;
			cat_q <= cat_d;
			flag_q <= flag_d;
		end
	end

	always_comb begin
		fault_flag_out_o = flag_q;
		code_line_1_o = code_q[0];
		code_line_2_o = code_q[1];
		code_line_3_o = code_q[2];
		category_o = cat_q;
	end
endmodule : sfce_top
`default_nettype wire
